// file: include/utc_regs.svh
// Purpose: register offsets, field positions, reset values and counts of the UART core
// Assumes: byte addresses on a 32-bit Avalon-MM slave, one register per aligned word
// Notes: data sits in the low byte, upper bits read as zero
`ifndef UTC_REGS_SVH
`define UTC_REGS_SVH
`define UTC_OFF_DATA 8'h00
`define UTC_OFF_STATUS 8'h04
`define UTC_OFF_CTRL 8'h08
`define UTC_OFF_DIV 8'h0C
`define UTC_OFF_DIR 8'h10
`define UTC_OFF_PORT 8'h14
`define UTC_ST_RXDONE 7
`define UTC_ST_TXDONE 6
`define UTC_ST_EMPTY 5
`define UTC_ST_FE 4
`define UTC_ST_OVR 3
`define UTC_CT_RX_ENABLE_BIT 4
`define UTC_CT_TX_ENABLE_BIT 3
`define UTC_CT_NINE 2
`define UTC_CT_RX9 1
`define UTC_CT_TX9 0
`define UTC_RST_RX9 1'b1
`define UTC_OVERSAMPLE 16
`define UTC_VOTE_FIRST 4'h8
`define UTC_VOTE_LAST 4'hA
`define UTC_BITS8 4'hA
`define UTC_BITS9 4'hB
`endif

// file: include/utc_pkg.sv
// Purpose: types of the UART core
// Assumes: constants come from utc_regs.svh
// Notes: whole core state is one packed struct
package utc_pkg;
    typedef enum logic [1:0] {
        UTC_RX_IDLE = 2'b00,
        UTC_RX_START = 2'b01,
        UTC_RX_DATA = 2'b10,
        UTC_RX_STOP = 2'b11
    } utc_rx_st_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } utc_av_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } utc_av_rsp_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic tx_en, rx_en, nine, tx9;
        logic [7:0] div;
        logic [1:0] dir;
        logic [1:0] pout;
        logic [7:0] pre;
        logic [3:0] sub;
        logic [7:0] thr;
        logic thr_full;
        logic [10:0] tsr;
        logic [3:0] tbits;
        logic tbusy;
        logic txline;
        logic tx_done;
        utc_rx_st_t rxs;
        logic [3:0] samp;
        logic [1:0] votes;
        logic [3:0] rbits;
        logic [8:0] rsh;
        logic [7:0] rdat;
        logic rb8;
        logic rfull;
        logic fe;
        logic ovr_pend;
        logic ovr;
    } utc_state_t;
endpackage

// file: logic/utc_core.sv
// Purpose: full-duplex asynchronous serial transmitter and receiver
// Assumes: pin inputs synchronous to clock, Avalon-MM master with waitrequest
// Notes: one wait state per access, no interrupt logic
//
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "utc_regs.svh"

module utc_core
    import utc_pkg::*;
#(
    parameter int OVERSAMPLE = `UTC_OVERSAMPLE
) (
    input wire logic clock,
    input wire logic rst,
    input wire utc_av_req_t avs_req,
    output utc_av_rsp_t avs_rsp,
    input wire logic line_one_i,
    output logic line_one_o,
    output logic line_one_oe,
    input wire logic line_zero_i,
    output logic line_zero_o,
    output logic line_zero_oe,
    output logic line_zero_pullup
);

    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    if (OVERSAMPLE != 16) begin : g_bad_ovs
        $error("utc_core: sample counter is built for sixteen samples per bit");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic sel(input logic [7:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction

    function automatic logic maj(input logic [1:0] ones);
        return ones >= 2'h2;
    endfunction

    localparam utc_state_t ST_RST = '{
        rxs: UTC_RX_IDLE,
        txline: 1'b1,
        rb8: `UTC_RST_RX9,
        default: '0
    };

    utc_state_t st_q;
    utc_state_t st_d;

    logic req;
    logic wr;
    logic rd;
    logic dp_wr;
    logic dp_rd;
    logic tick16;
    logic btick;
    logic ld;
    logic xfer;
    logic xfer_fe;
    logic [3:0] s_nxt;
    logic [1:0] v_nxt;
    logic m_nxt;
    logic [7:0] rmux;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait state so read data is registered before it is taken

    assign req = avs_req.read | avs_req.write;
    assign avs_rsp = '{readdata: st_q.rdata, waitrequest: req & ~st_q.ack};
    assign wr = avs_req.write & st_q.ack & avs_req.byteenable[0];
    assign rd = avs_req.read & st_q.ack;
    assign dp_wr = wr & sel(avs_req.address, `UTC_OFF_DATA);
    assign dp_rd = rd & sel(avs_req.address, `UTC_OFF_DATA);

    always_comb begin
        rmux = 8'h00;
        if (sel(avs_req.address, `UTC_OFF_DATA)) begin
            rmux = st_q.rdat;
        end else if (sel(avs_req.address, `UTC_OFF_STATUS)) begin
            rmux[`UTC_ST_RXDONE] = st_q.rfull;
            rmux[`UTC_ST_TXDONE] = st_q.tx_done;
            rmux[`UTC_ST_EMPTY] = ~st_q.thr_full;
            rmux[`UTC_ST_FE] = st_q.fe;
            rmux[`UTC_ST_OVR] = st_q.ovr;
        end else if (sel(avs_req.address, `UTC_OFF_CTRL)) begin
            rmux[`UTC_CT_RX_ENABLE_BIT] = st_q.rx_en;
            rmux[`UTC_CT_TX_ENABLE_BIT] = st_q.tx_en;
            rmux[`UTC_CT_NINE] = st_q.nine;
            rmux[`UTC_CT_RX9] = st_q.rb8;
        end else if (sel(avs_req.address, `UTC_OFF_DIV)) begin
            rmux = st_q.div;
        end else if (sel(avs_req.address, `UTC_OFF_DIR)) begin
            rmux = {6'h00, st_q.dir};
        end else if (sel(avs_req.address, `UTC_OFF_PORT)) begin
            rmux = {6'h00, st_q.pout};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Baud generator: free running; the transmitter steps on its bit tick, the receiver counts its own bit phase from the oversample tick

    assign tick16 = st_q.pre == st_q.div;
    assign btick = tick16 & (st_q.sub == 4'hF);

    // Load is allowed while a stop bit is still on the line; it only ends at the next tick
    assign ld = st_q.thr_full & (st_q.tbits == 4'h0) & (st_q.tx_en | st_q.tbusy);

    ////////////////////////////////////////////////////////////////////////////////
    // Receiver sample arithmetic

    assign s_nxt = st_q.samp + 4'h1;

    always_comb begin
        v_nxt = st_q.votes;
        if (s_nxt == 4'h0) begin
            v_nxt = 2'h0;
        end else if (s_nxt >= `UTC_VOTE_FIRST && s_nxt <= `UTC_VOTE_LAST && line_zero_i) begin
            v_nxt = st_q.votes + 2'h1;
        end
    end

    assign m_nxt = maj(v_nxt);

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_d = st_q;
        xfer = 1'b0;
        xfer_fe = 1'b0;

        // Bus handshake
        st_d.ack = req & ~st_q.ack;
        if (req & ~st_q.ack) begin
            st_d.rdata = {24'h000000, rmux};
        end

        // Register writes
        if (wr & sel(avs_req.address, `UTC_OFF_CTRL)) begin
            st_d.rx_en = avs_req.writedata[`UTC_CT_RX_ENABLE_BIT];
            st_d.tx_en = avs_req.writedata[`UTC_CT_TX_ENABLE_BIT];
            st_d.nine = avs_req.writedata[`UTC_CT_NINE];
            st_d.tx9 = avs_req.writedata[`UTC_CT_TX9];
        end else if (wr & sel(avs_req.address, `UTC_OFF_DIV)) begin
            st_d.div = avs_req.writedata[7:0];
        end else if (wr & sel(avs_req.address, `UTC_OFF_DIR)) begin
            st_d.dir = avs_req.writedata[1:0];
        end else if (wr & sel(avs_req.address, `UTC_OFF_PORT)) begin
            st_d.pout = avs_req.writedata[1:0];
        end

        // Baud counters
        st_d.pre = tick16 ? 8'h00 : st_q.pre + 8'h01;
        if (tick16) begin
            st_d.sub = st_q.sub + 4'h1;
        end

        // Clear before the transmitter so a completion in the same cycle wins
        if (wr && sel(avs_req.address, `UTC_OFF_STATUS)
            && avs_req.writedata[`UTC_ST_TXDONE]) begin
            st_d.tx_done = 1'b0;
        end

        // Transmitter
        if (ld) begin
            st_d.tsr = {1'b1, st_q.nine ? st_q.tx9 : 1'b1, st_q.thr, 1'b0};
            st_d.tbits = st_q.nine ? `UTC_BITS9 : `UTC_BITS8;
            st_d.tbusy = 1'b1;
            st_d.thr_full = 1'b0;
        end else if (btick && st_q.tbits != 4'h0) begin
            st_d.txline = st_q.tsr[0];
            st_d.tsr = {1'b1, st_q.tsr[10:1]};
            st_d.tbits = st_q.tbits - 4'h1;
        end else if (btick && st_q.tbusy) begin
            st_d.tbusy = 1'b0;
            st_d.tx_done = 1'b1;
        end
        if (!st_d.tbusy) begin
            st_d.txline = 1'b1;
        end
        if (dp_wr) begin
            st_d.thr = avs_req.writedata[7:0];
            st_d.thr_full = 1'b1;
        end

        // Receiver; disabling it leaves the flags alone
        if (!st_q.rx_en) begin
            st_d.rxs = UTC_RX_IDLE;
        end else if (tick16) begin
            case (st_q.rxs)
                UTC_RX_IDLE: begin
                    if (!line_zero_i) begin
                        st_d.rxs = UTC_RX_START;
                        st_d.samp = 4'h1;
                        st_d.votes = 2'h0;
                        st_d.rbits = 4'h0;
                    end
                end
                UTC_RX_START: begin
                    st_d.samp = s_nxt;
                    st_d.votes = v_nxt;
                    if (s_nxt == `UTC_VOTE_LAST) begin
                        st_d.rxs = m_nxt ? UTC_RX_IDLE : UTC_RX_DATA;
                    end
                end
                UTC_RX_DATA: begin
                    st_d.samp = s_nxt;
                    st_d.votes = v_nxt;
                    if (s_nxt == `UTC_VOTE_LAST) begin
                        st_d.rsh = {m_nxt, st_q.rsh[8:1]};
                        if (st_q.rbits == (st_q.nine ? 4'h8 : 4'h7)) begin
                            st_d.rxs = UTC_RX_STOP;
                        end else begin
                            st_d.rbits = st_q.rbits + 4'h1;
                        end
                    end
                end
                UTC_RX_STOP: begin
                    st_d.samp = s_nxt;
                    st_d.votes = v_nxt;
                    if (s_nxt == `UTC_VOTE_LAST) begin
                        // Ending at sample 10 leaves six samples of the stop bit to catch the next start
                        st_d.rxs = UTC_RX_IDLE;
                        xfer = 1'b1;
                        xfer_fe = ~m_nxt;
                    end
                end
                default: begin
                    st_d.rxs = UTC_RX_IDLE;
                end
            endcase
        end

        // Reading data clears the flag first so a same-cycle arrival is kept
        if (dp_rd) begin
            st_d.rfull = 1'b0;
            st_d.ovr = st_q.ovr_pend;
            st_d.ovr_pend = 1'b0;
        end
        if (xfer) begin
            if (st_d.rfull) begin
                st_d.ovr_pend = 1'b1;
            end else begin
                st_d.rdat = st_q.nine ? st_d.rsh[7:0] : st_d.rsh[8:1];
                if (st_q.nine) begin
                    st_d.rb8 = st_d.rsh[8];
                end
                st_d.rfull = 1'b1;
                st_d.fe = xfer_fe;
                st_d.ovr = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin multiplexing

    always_comb begin
        line_one_oe = st_q.tx_en | st_q.tbusy | st_q.dir[1];
        line_one_o = (st_q.tx_en | st_q.tbusy) ? st_q.txline : st_q.pout[1];
        line_zero_oe = st_q.rx_en ? 1'b0 : st_q.dir[0];
        line_zero_o = st_q.pout[0];
        line_zero_pullup = st_q.pout[0] & ~line_zero_oe;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_quiet1;
        !tick16;
    endsequence

    sequence s_tick_after1;
        s_quiet1 ##1 tick16;
    endsequence

    property p_load_empties;
        @(posedge clock) disable iff (rst)
        ld && !dp_wr |=> !st_q.thr_full && st_q.tbusy;
    endproperty
    a_load_empties: assert property (p_load_empties)
        else $error("load did not empty holding register");

    property p_frame_bits;
        @(posedge clock) disable iff (rst)
        ld |=> !st_q.tsr[0] && (st_q.nine ? st_q.tsr[10] : st_q.tsr[9]);
    endproperty
    a_frame_bits: assert property (p_frame_bits)
        else $error("start or stop bit wrong after load");

    property p_ninth_copy;
        @(posedge clock) disable iff (rst)
        ld && st_q.nine |=> st_q.tsr[9] == $past(st_q.tx9);
    endproperty
    a_ninth_copy: assert property (p_ninth_copy)
        else $error("ninth bit not copied on load");

    property p_start_out;
        @(posedge clock) disable iff (rst)
        btick && st_q.tbits == (st_q.nine ? `UTC_BITS9 : `UTC_BITS8) |=> !line_one_o;
    endproperty
    a_start_out: assert property (p_start_out)
        else $error("start bit not driven");

    property p_done_after_stop;
        @(posedge clock) disable iff (rst)
        btick && st_q.tbusy && st_q.tbits == 4'h0 && !st_q.thr_full |=> st_q.tx_done;
    endproperty
    a_done_after_stop: assert property (p_done_after_stop)
        else $error("transmit done not set");

    property p_tx_pin;
        @(posedge clock) disable iff (rst)
        st_q.tx_en |-> line_one_oe && (st_q.tbusy || line_one_o);
    endproperty
    a_tx_pin: assert property (p_tx_pin)
        else $error("transmit pin not owned or not idle high");

    property p_reject;
        @(posedge clock) disable iff (rst)
        tick16 && st_q.rx_en && st_q.rxs == UTC_RX_START && s_nxt == `UTC_VOTE_LAST
        && m_nxt |=> st_q.rxs == UTC_RX_IDLE;
    endproperty
    a_reject: assert property (p_reject)
        else $error("noisy start not rejected");

    property p_deliver;
        @(posedge clock) disable iff (rst)
        xfer && !(st_q.rfull && !dp_rd) |=> st_q.rfull && st_q.fe == $past(xfer_fe);
    endproperty
    a_deliver: assert property (p_deliver)
        else $error("character not delivered");

    property p_overrun;
        @(posedge clock) disable iff (rst)
        xfer && st_q.rfull && !dp_rd |=> st_q.ovr_pend && $stable(st_q.rdat);
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not handled");

    property p_read_clears;
        @(posedge clock) disable iff (rst)
        dp_rd && !xfer |=> !st_q.rfull && st_q.ovr == $past(st_q.ovr_pend);
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("data read did not clear or expose overrun");

    property p_rx_pin;
        @(posedge clock) disable iff (rst)
        st_q.rx_en |-> !line_zero_oe && line_zero_pullup == st_q.pout[0];
    endproperty
    a_rx_pin: assert property (p_rx_pin)
        else $error("receive pin not forced to input");

    property p_baud1;
        @(posedge clock) disable iff (rst)
        tick16 && st_q.div == 8'h01 && !wr |=> s_tick_after1;
    endproperty
    a_baud1: assert property (p_baud1)
        else $error("oversample tick spacing wrong");

endmodule

// file: dv/utc_remote.sv
// Purpose: remote serial node on the far side of the UART core
// Assumes: bit time of BITCLK clocks, idle line high
// Notes: stop level, mid-bit glitches and spikes only when the bench asks
`timescale 1ns/1ps
module utc_remote #(
    parameter int BITCLK = 32
) (
    input wire logic clock,
    input wire logic txw,
    input wire logic nine,
    output logic rxl
);
    logic [9:0] got_q[$];
    logic [9:0] f;
    initial rxl = 1'b1;
    ////////////////////////////////////////////////////////////////////////
    // Receiver: samples each bit in its middle, stores {stop, data}
    always begin
        @(posedge clock iff txw === 1'b0);
        f = '0;
        repeat (BITCLK / 2) @(posedge clock);
        for (int i = 0; i < (nine ? 10 : 9); i++) begin
            repeat (BITCLK) @(posedge clock);
            f[i] = txw;
        end
        got_q.push_back(f);
    end
    ////////////////////////////////////////////////////////////////////////
    // Glitch flips one oversample slot mid-bit, so a vote still wins
    task automatic send(input logic [8:0] d, input logic n9, input logic stp,
                        input logic gl);
        logic [10:0] fr;
        fr = {stp, d, 1'b0};
        if (!n9)
            fr[9] = stp;
        for (int i = 0; i < (n9 ? 11 : 10); i++) begin
            rxl <= fr[i];
            repeat (BITCLK / 2) @(posedge clock);
            if (gl && i > 0 && i < (n9 ? 10 : 9))
                rxl <= ~fr[i];
            repeat (BITCLK / 16) @(posedge clock);
            rxl <= fr[i];
            repeat (BITCLK / 2 - BITCLK / 16) @(posedge clock);
        end
        rxl <= 1'b1;
        @(posedge clock);
    endtask
    task automatic spike(input int c);
        rxl <= 1'b0;
        repeat (c) @(posedge clock);
        rxl <= 1'b1;
        repeat (BITCLK * 2) @(posedge clock);
    endtask
endmodule

// file: dv/tb_top.sv
// Purpose: self-checking bench of the UART core
// Assumes: divisor 1, so a bit lasts 32 clocks
// Notes: the output pin idles high through a pull-up when not driven
`timescale 1ns/1ps
`include "utc_regs.svh"
module tb_top;
    import utc_pkg::*;
    localparam int DIV = 1;
    localparam int BC = 16 * (DIV + 1);
    logic clock = 1'b0;
    logic rst = 1'b1;
    utc_av_req_t req = '0;
    utc_av_rsp_t rsp;
    logic l1o, l1oe, l0o, l0oe, l0pu, rxl;
    logic nine = 1'b0;
    logic [31:0] q;
    int n_errors = 0;
    int checks = 0;
    wire txw = l1oe ? l1o : 1'b1;
    wire l0 = l0oe ? l0o : rxl;
    always #25 clock = ~clock;
    utc_core dut_u (.clock(clock), .rst(rst), .avs_req(req), .avs_rsp(rsp),
        .line_one_i(txw), .line_one_o(l1o), .line_one_oe(l1oe), .line_zero_i(l0),
        .line_zero_o(l0o), .line_zero_oe(l0oe), .line_zero_pullup(l0pu));
    utc_remote #(.BITCLK(BC)) rem_u (.clock(clock), .txw(txw), .nine(nine), .rxl(rxl));
    ////////////////////////////////////////////////////////////////////////
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clock);
        req <= '{~w, w, a, 4'hF, {24'h0, d}};
        do begin
            @(posedge clock);
            k++;
        end while (rsp.waitrequest !== 1'b0 && k < 50);
        q = rsp.readdata;
        req <= '0;
        if (k >= 50)
            n_errors++;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 8'h00);
        chk(q, e);
    endtask
    task automatic wait_q(input int n);
        int k;
        k = 0;
        while (rem_u.got_q.size() < n && k < 2000) begin
            @(posedge clock);
            k++;
        end
        if (k >= 2000)
            n_errors++;
    endtask
    task finish_test;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Frames take 320 clocks each, 352 with a ninth bit; limit leaves wide margin
    initial begin
        repeat (60000) @(posedge clock);
        n_errors++;
        finish_test;
    end
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        rd(`UTC_OFF_STATUS, 32'h20);
        rd(`UTC_OFF_CTRL, 32'h02);
        chk(l1oe, 1'b0);
        $display("reset test done");
        acc(1'b1, `UTC_OFF_DIV, 8'h01);
        // Enable first so the output pin never drives low before the frames
        acc(1'b1, `UTC_OFF_CTRL, 8'h18);
        acc(1'b1, `UTC_OFF_DIR, 8'h03);
        acc(1'b1, `UTC_OFF_PORT, 8'h01);
        @(negedge clock);
        chk({l1oe, l1o, l0oe, l0pu}, 4'hD);
        rd(8'h1C, 32'h0);
        acc(1'b1, 8'h1C, 8'hFF);
        rd(`UTC_OFF_DIV, 32'h01);
        $display("pin and map test done");
        // Second write lands while the first character is still shifting
        acc(1'b1, `UTC_OFF_DATA, 8'hA5);
        acc(1'b1, `UTC_OFF_DATA, 8'h3C);
        rd(`UTC_OFF_STATUS, 32'h00);
        wait_q(2);
        chk(rem_u.got_q.pop_front(), 10'h1A5);
        chk(rem_u.got_q.pop_front(), 10'h13C);
        rd(`UTC_OFF_STATUS, 32'h20);
        repeat (BC * 2) @(posedge clock);
        rd(`UTC_OFF_STATUS, 32'h60);
        acc(1'b1, `UTC_OFF_STATUS, 8'h40);
        rd(`UTC_OFF_STATUS, 32'h20);
        $display("transmit test done");
        nine <= 1'b1;
        for (int b = 0; b < 2; b++) begin
            acc(1'b1, `UTC_OFF_CTRL, 8'h1C | b[7:0]);
            acc(1'b1, `UTC_OFF_DATA, 8'h81);
            wait_q(1);
            chk(rem_u.got_q.pop_front(), {1'b1, b[0], 8'h81});
            repeat (BC * 2) @(posedge clock);
            acc(1'b1, `UTC_OFF_STATUS, 8'h40);
        end
        for (int b = 0; b < 2; b++) begin
            rem_u.send({b[0], 8'hC3}, 1'b1, 1'b1, 1'b0);
            rd(`UTC_OFF_CTRL, {26'h0, 4'h7, b[0], 1'b0});
            rd(`UTC_OFF_DATA, 32'hC3);
        end
        $display("nine bit test done");
        nine <= 1'b0;
        acc(1'b1, `UTC_OFF_CTRL, 8'h18);
        rem_u.send(9'h05A, 1'b0, 1'b1, 1'b1);
        rd(`UTC_OFF_STATUS, 32'hA0);
        rd(`UTC_OFF_DATA, 32'h5A);
        rd(`UTC_OFF_STATUS, 32'h20);
        rem_u.send(9'h033, 1'b0, 1'b0, 1'b0);
        rd(`UTC_OFF_STATUS, 32'hB0);
        rd(`UTC_OFF_DATA, 32'h33);
        $display("receive test done");
        rem_u.send(9'h011, 1'b0, 1'b1, 1'b0);
        rem_u.send(9'h022, 1'b0, 1'b1, 1'b0);
        rd(`UTC_OFF_STATUS, 32'hA0);
        rd(`UTC_OFF_DATA, 32'h11);
        rd(`UTC_OFF_STATUS, 32'h28);
        rem_u.send(9'h044, 1'b0, 1'b1, 1'b0);
        rd(`UTC_OFF_STATUS, 32'hA0);
        rd(`UTC_OFF_DATA, 32'h44);
        $display("overrun test done");
        rem_u.spike(6);
        rd(`UTC_OFF_STATUS, 32'h20);
        rem_u.send(9'h069, 1'b0, 1'b1, 1'b0);
        rd(`UTC_OFF_DATA, 32'h69);
        $display("noise test done");
        acc(1'b1, `UTC_OFF_CTRL, 8'h00);
        @(negedge clock);
        chk({l1oe, l1o, l0oe, l0pu}, 4'hA);
        chk(l0o, 1'b1);
        $display("disable test done");
        finish_test;
    end
endmodule
